// ==== rtl/atpr_cfg.svh ====
// Constants of the converter readout link.
`ifndef ATPR_CFG_SVH
`define ATPR_CFG_SVH
`define ATPR_CMD_WR_CFG1   8'h44
`define ATPR_CMD_WR_MASK   8'hf0
`define ATPR_CMD_WR_BASE   8'h40
`define ATPR_CMD_REG_LSB   2
`define ATPR_CMD_CNT_LSB   0
`define ATPR_CFG_TSEL_BIT  1
`define ATPR_CFG_RATE_LSB  5
`define ATPR_CFG_ONE_BIT   2
`define ATPR_CFG_FRAME_BITS 16
`define ATPR_CFG_RESET     8'h04
`define ATPR_RESULT_BITS   24
`define ATPR_TEMP_BITS     14
`define ATPR_TEMP_PAD_BITS 10
`define ATPR_PRES_MAX      24'h7fffff
`define ATPR_PRES_MIN      24'h800000
`define ATPR_SYS_PERIOD_NS 25
`define ATPR_SCLK_HALF_NS  100
`define ATPR_SCLK_HALF_CYC ((`ATPR_SCLK_HALF_NS + `ATPR_SYS_PERIOD_NS - 1) / `ATPR_SYS_PERIOD_NS)
`endif

// ==== rtl/atpr_pkg.sv ====
// Types of the converter readout link; the host end uses the state type, the converter end uses none.
`default_nettype none
package atpr_pkg;
    typedef enum {ATPR_MEAS_PRESSURE, ATPR_MEAS_TEMPERATURE} atpr_meas_t;
    typedef enum {ATPR_H_IDLE, ATPR_H_SEL, ATPR_H_SHIFT, ATPR_H_DONE} atpr_hstate_t;
endpackage : atpr_pkg
`default_nettype wire

// ==== rtl/atpr_link_if.sv ====
// Serial link between the converter end and the host end.
`default_nettype none
interface atpr_link_if;
    logic conv_select_n;
    logic memory_select_n;
    logic sclk;
    logic sdi;
    logic sdo;
    modport device (input conv_select_n, memory_select_n, sclk, sdi, output sdo);
    modport host (output conv_select_n, memory_select_n, sclk, sdi, input sdo);
endinterface : atpr_link_if
`default_nettype wire

// ==== rtl/atpr_fifo.sv ====
// Result FIFO with valid and ready on both sides.
`default_nettype none
module atpr_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_sys_rst,
    // Fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Drain side
    output logic                  o_out_valid,
    output logic      [WIDTH-1:0] o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    initial if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) $error("bad FIFO shape");
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;
    logic             push;
    logic             pop;
    assign o_in_ready  = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
    assign o_out_valid = wr_ptr_r != rd_ptr_r;
    assign o_out_data  = mem[rd_ptr_r[AW-1:0]];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    always_ff @(posedge i_clk_sys)
        if (push)
            mem[wr_ptr_r[AW-1:0]] <= i_in_data;
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        if (i_sys_rst)
            wr_ptr_r <= '0;
        else if (push)
            wr_ptr_r <= wr_ptr_r + 1'b1;
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        if (i_sys_rst)
            rd_ptr_r <= '0;
        else if (pop)
            rd_ptr_r <= rd_ptr_r + 1'b1;
endmodule : atpr_fifo
`default_nettype wire

// ==== rtl/atpr_device.sv ====
// Converter end: takes configuration writes and shifts out results.
`include "atpr_cfg.svh"
`default_nettype none
module atpr_device
    import atpr_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    // Link
    atpr_link_if.device      link,
    // Measurement source
    input  wire logic [23:0] i_pres_code,
    input  wire logic [13:0] i_temp_code,
    input  wire logic [9:0]  i_pad_bits,
    // Status
    output logic [7:0]       o_config1,
    output logic             o_cfg_pulse
);
    logic [1:0]  cs_sync_r;
    logic [1:0]  sck_sync_r;
    logic [1:0]  sdi_sync_r;
    logic        sck_d_r;
    logic [23:0] shift_r;
    logic [7:0]  cmd_r;
    logic [7:0]  rx_r;
    logic [2:0]  bit_cnt_r;
    logic [1:0]  data_left_r;
    logic [1:0]  reg_sel_r;
    logic        in_data_r;
    logic        sdo_r;
    logic        sel;
    logic        rise;
    logic        fall;
    logic [7:0]  rx_nxt;

    // Result word: temperature padded after 14 bits, pressure whole.
    function automatic logic [23:0] result(input logic [7:0] cfg);
        if (cfg[`ATPR_CFG_TSEL_BIT])
            return {i_temp_code, i_pad_bits};
        return i_pres_code;
    endfunction : result

    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        if (i_sys_rst)
        begin
            cs_sync_r  <= 2'h3;
            sck_sync_r <= 2'h0;
            sdi_sync_r <= 2'h0;
            sck_d_r    <= 1'b0;
        end
        else
        begin
            cs_sync_r  <= {cs_sync_r[0], link.conv_select_n};
            sck_sync_r <= {sck_sync_r[0], link.sclk};
            sdi_sync_r <= {sdi_sync_r[0], link.sdi};
            sck_d_r    <= sck_sync_r[1];
        end

    assign sel    = !cs_sync_r[1];
    assign rise   = sel && sck_sync_r[1] && !sck_d_r;
    assign fall   = sel && !sck_sync_r[1] && sck_d_r;
    assign rx_nxt = {rx_r[6:0], sdi_sync_r[1]};

    // Command and configuration bytes, sampled on falling edges.
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        if (i_sys_rst)
        begin
            rx_r        <= 8'h00;
            bit_cnt_r   <= 3'h0;
            in_data_r   <= 1'b0;
            data_left_r <= 2'h0;
            reg_sel_r   <= 2'h0;
            cmd_r       <= 8'h00;
            o_config1   <= `ATPR_CFG_RESET;
            o_cfg_pulse <= 1'b0;
        end
        else
        begin
            o_cfg_pulse <= 1'b0;
            if (!sel)
            begin
                bit_cnt_r <= 3'h0;
                in_data_r <= 1'b0;
            end
            else if (fall)
            begin
                rx_r      <= rx_nxt;
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (bit_cnt_r == 3'h7)
                begin
                    if (in_data_r)
                    begin
                        if (reg_sel_r == 2'h1)
                        begin
                            o_config1   <= rx_nxt;
                            o_cfg_pulse <= 1'b1;
                        end
                        reg_sel_r   <= reg_sel_r + 2'h1;
                        data_left_r <= data_left_r - 2'h1;
                        in_data_r   <= data_left_r != 2'h0;
                    end
                    else if ((rx_nxt & `ATPR_CMD_WR_MASK) == `ATPR_CMD_WR_BASE)
                    begin
                        cmd_r       <= rx_nxt;
                        reg_sel_r   <= rx_nxt[`ATPR_CMD_REG_LSB +: 2];
                        data_left_r <= rx_nxt[`ATPR_CMD_CNT_LSB +: 2];
                        in_data_r   <= 1'b1;
                    end
                end
            end
        end

    // Result shifter; a new word loads on every cycle while the converter is deselected.
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        if (i_sys_rst)
        begin
            shift_r <= 24'h000000;
            sdo_r   <= 1'b0;
        end
        else if (!sel)
            shift_r <= result(o_config1);
        else if (rise)
        begin
            sdo_r   <= shift_r[23];
            shift_r <= {shift_r[22:0], 1'b0};
        end

    assign link.sdo = sdo_r;
endmodule : atpr_device
`default_nettype wire

// ==== rtl/atpr_host.sv ====
// Host end: writes configuration, then reads 24-bit results.
// Contract
// - Converter select held low for every frame.
// - Command 0100 0100 then one configuration byte.
// - Temperature reading sets configuration bit one.
// - Pressure reading clears configuration bit one.
// - Result bits follow the first rising clock.
// - Temperature: leading 14 bits, 10 discarded; the host hands all 24 bits on.
// - Temperature code is two's complement.
// - Celsius is signed code times 0.03125.
// - Pressure word 24 bits, most significant first.
// - Pressure code saturates at full scale.
// - Clock idles low, sampled on second edge.
// - Memory select never low with converter select.
// - Command holds register and count minus one.
// - New settings apply after the write.
`include "atpr_cfg.svh"
`default_nettype none
module atpr_host
    import atpr_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int HALF_CYC   = `ATPR_SCLK_HALF_CYC
)
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    // Link
    atpr_link_if.host        link,
    // Request
    input  wire logic        i_req,
    input  wire logic        i_temp_sel,
    input  wire logic [2:0]  i_rate,
    output logic             o_busy,
    // Results
    output logic             o_res_valid,
    output logic [23:0]      o_res_data,
    input  wire logic        i_res_ready
);
    localparam int GAP_CYC  = 2 * HALF_CYC;
    localparam int CNT_BITS = $clog2(GAP_CYC + 1);

    // A clock phase must outlast the far end's pin latency and the link monitor's four-sample high check.
    if (HALF_CYC < 4 || FIFO_DEPTH < 2)
    begin : g_bad_shape
        $error("host timing or buffer shape not served");
    end

    atpr_hstate_t        state_r;
    logic [CNT_BITS-1:0] cnt_r;
    logic [4:0]          bit_cnt_r;
    logic                frame_rd_r;
    logic [15:0]         tx_r;
    logic [23:0]         rx_r;
    logic [1:0]          sdo_sync_r;
    logic                sclk_r;
    logic                sdi_r;
    logic                cs_n_r;
    logic                push_r;
    logic [23:0]         res_r;
    logic [23:0]         rx_nxt;
    logic                push_ready;
    logic                phase_end;
    logic                gap_end;
    logic                last_bit;
    logic                start;
    logic                rise_go;
    logic                fall_go;
    logic                sample;
    logic                frame_end;
    logic                reselect;
    logic                finish;

    // Configuration byte for register 1: data rate, normal mode, fixed one, sensor choice.
    function automatic logic [7:0] cfg_byte(input logic temp_sel, input logic [2:0] rate);
        logic [7:0] cfg;
        cfg                          = 8'h00;
        cfg[`ATPR_CFG_RATE_LSB +: 3] = rate;
        cfg[`ATPR_CFG_ONE_BIT]       = 1'b1;
        cfg[`ATPR_CFG_TSEL_BIT]      = temp_sel;
        return cfg;
    endfunction : cfg_byte

    // Index of the last bit of a frame, for the command frame or the result frame.
    function automatic logic [4:0] last_index(input logic read_frame);
        if (read_frame)
            return 5'(`ATPR_RESULT_BITS - 1);
        return 5'(`ATPR_CFG_FRAME_BITS - 1);
    endfunction : last_index

    // The result pin crosses from the far end and passes two flip-flops.
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        if (i_sys_rst)
            sdo_sync_r <= 2'h0;
        else
            sdo_sync_r <= {sdo_sync_r[0], link.sdo};

    assign rx_nxt    = {rx_r[22:0], sdo_sync_r[1]};
    assign phase_end = cnt_r == CNT_BITS'(HALF_CYC - 1);
    assign gap_end   = cnt_r == CNT_BITS'(GAP_CYC - 1);
    assign last_bit  = bit_cnt_r == last_index(frame_rd_r);
    assign start     = state_r == ATPR_H_IDLE && i_req;
    assign rise_go   = (state_r == ATPR_H_SEL && phase_end)
                       || (sample && !last_bit);
    assign fall_go   = state_r == ATPR_H_SHIFT && sclk_r && phase_end;
    assign sample    = state_r == ATPR_H_SHIFT && !sclk_r && phase_end;
    assign frame_end = sample && last_bit;
    assign reselect  = state_r == ATPR_H_DONE && gap_end && !frame_rd_r;
    assign finish    = state_r == ATPR_H_DONE && gap_end && frame_rd_r && !push_r;
    assign o_busy    = state_r != ATPR_H_IDLE;

    // Frame sequencing: select, clock the bits, then a deselected gap.
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        if (i_sys_rst)
            state_r <= ATPR_H_IDLE;
        else
        begin
            unique case (state_r)
                ATPR_H_IDLE:
                    if (start)
                        state_r <= ATPR_H_SEL;
                ATPR_H_SEL:
                    if (phase_end)
                        state_r <= ATPR_H_SHIFT;
                ATPR_H_SHIFT:
                    if (frame_end)
                        state_r <= ATPR_H_DONE;
                ATPR_H_DONE:
                    if (reselect)
                        state_r <= ATPR_H_SEL;
                    else if (finish)
                        state_r <= ATPR_H_IDLE;
            endcase
        end

    // Cycle counter of the clock phases and of the gap between frames.
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        if (i_sys_rst)
            cnt_r <= '0;
        else if (start || rise_go || fall_go || sample || reselect)
            cnt_r <= '0;
        else if (!gap_end)
            cnt_r <= cnt_r + 1'b1;

    // Bit counter and frame kind; the second frame of a request reads the result.
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        if (i_sys_rst)
        begin
            bit_cnt_r  <= 5'h00;
            frame_rd_r <= 1'b0;
        end
        else
        begin
            if (start || reselect)
                bit_cnt_r <= 5'h00;
            else if (sample)
                bit_cnt_r <= bit_cnt_r + 5'h01;
            if (start)
                frame_rd_r <= 1'b0;
            else if (reselect)
                frame_rd_r <= 1'b1;
        end

    // Command and configuration leave most significant bit first; the read frame sends zeros.
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        if (i_sys_rst)
        begin
            tx_r  <= 16'h0000;
            sdi_r <= 1'b0;
        end
        else if (start)
            tx_r <= {`ATPR_CMD_WR_CFG1, cfg_byte(i_temp_sel, i_rate)};
        else if (reselect)
            tx_r <= 16'h0000;
        else if (rise_go)
        begin
            sdi_r <= tx_r[15];
            tx_r  <= {tx_r[14:0], 1'b0};
        end

    // Link clock from a divider; it idles low between frames.
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        if (i_sys_rst)
            sclk_r <= 1'b0;
        else if (rise_go)
            sclk_r <= 1'b1;
        else if (fall_go)
            sclk_r <= 1'b0;

    // Converter select stays low from before the first bit until after the last one.
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        if (i_sys_rst)
            cs_n_r <= 1'b1;
        else if (start || reselect)
            cs_n_r <= 1'b0;
        else if (frame_end)
            cs_n_r <= 1'b1;

    // Result bits are taken at the end of the low phase, long settled after the rise.
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        if (i_sys_rst)
            rx_r <= 24'h000000;
        else if (sample)
            rx_r <= rx_nxt;

    // The word is handed on whole, with its sign at the top of the field it carries.
    // Downstream sign-extends from bit 23, or from bit 13 of the 14-bit temperature field.
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
        if (i_sys_rst)
        begin
            push_r <= 1'b0;
            res_r  <= 24'h000000;
        end
        else if (frame_end && frame_rd_r)
        begin
            push_r <= 1'b1;
            res_r  <= rx_nxt;
        end
        else if (push_ready)
            push_r <= 1'b0;

    atpr_fifo #(
        .WIDTH (`ATPR_RESULT_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_atpr_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_sys_rst   (i_sys_rst),
        .i_in_valid  (push_r),
        .i_in_data   (res_r),
        .o_in_ready  (push_ready),
        .o_out_valid (o_res_valid),
        .o_out_data  (o_res_data),
        .i_out_ready (i_res_ready)
    );

    assign link.conv_select_n   = cs_n_r;
    assign link.memory_select_n = 1'b1;
    assign link.sclk            = sclk_r;
    assign link.sdi             = sdi_r;
endmodule : atpr_host
`default_nettype wire

// ==== tb/atpr_link_monitor.sv ====
// Checker of the serial link between the host end and the converter end.
`default_nettype none
module atpr_link_monitor (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic conv_select_n,
    input wire logic memory_select_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);
    sequence s_low_run;
        !sclk && !$fell(sclk) && !conv_select_n && $stable(conv_select_n);
    endsequence
    a_sel_exclusive: assert property (conv_select_n || memory_select_n)
        else $error("both selects low");
    a_clk_idle_low: assert property (conv_select_n |-> !sclk)
        else $error("clock high while idle");
    a_rise_selected: assert property ($rose(sclk) |-> !conv_select_n)
        else $error("clock edge without select");
    a_sel_clk_low: assert property ($fell(conv_select_n) |-> !sclk)
        else $error("select fell with clock high");
    a_high_phase: assert property ($rose(sclk) |-> sclk [*4])
        else $error("clock high phase short");
    a_sdi_held: assert property (s_low_run |-> $stable(sdi))
        else $error("host data moved in low phase");
    a_sdo_held: assert property (s_low_run |-> $stable(sdo))
        else $error("device data moved in low phase");
    a_fall_sdi_set: assert property ($fell(sclk) |-> $stable(sdi))
        else $error("host data moved at sample edge");
endmodule : atpr_link_monitor
`default_nettype wire

// ==== tb/tb.sv ====
// Bench joining the host end to the converter end.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk_sys = 0, i_sys_rst = 1, i_req = 0, ts_r = 0, rdy = 0;
    logic [2:0]  rate = 0;
    logic [23:0] pres = 0;
    logic [13:0] temp = 0;
    logic [9:0]  pad = 0;
    logic        busy, vld;
    logic [23:0] res;
    logic [7:0]  cfg1;
    logic [23:0] exp_q[$];
    int          error_cnt = 0, cmp_count = 0, seed = 39, n;
    always #12.5 i_clk_sys = ~i_clk_sys;
    atpr_link_if link ();
    atpr_host u_atpr_host (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .link(link.host),
        .i_req(i_req), .i_temp_sel(ts_r), .i_rate(rate), .o_busy(busy),
        .o_res_valid(vld), .o_res_data(res), .i_res_ready(rdy));
    atpr_device u_atpr_device (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .link(link.device), .i_pres_code(pres), .i_temp_code(temp), .i_pad_bits(pad),
        .o_config1(cfg1), .o_cfg_pulse());
    atpr_link_monitor u_atpr_link_monitor (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .conv_select_n(link.conv_select_n), .memory_select_n(link.memory_select_n),
        .sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo));
    task automatic end_of_test;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic cmp_res(input logic [23:0] got, input logic [23:0] want);
        cmp_count++;
        if (got !== want)
        begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask : cmp_res
    task automatic cmp_cfg(input logic [7:0] got, input logic [7:0] want);
        cmp_res({16'h0000, got}, {16'h0000, want});
    endtask : cmp_cfg
    task automatic wait_busy(input logic want);
        n = 0;
        while (busy !== want)
        begin
            @(posedge i_clk_sys);
            #2;
            n++;
            if (n > 3000)
            begin
                error_cnt++;
                $display("BAD %0t timeout", $time);
                end_of_test();
            end
        end
    endtask : wait_busy
    task automatic run(input logic ts, input logic [23:0] p, input logic [13:0] t);
        @(posedge i_clk_sys);
        #2;
        ts_r = ts;
        rate = 3'($random(seed));
        pres = p;
        temp = t;
        pad = 10'($random(seed));
        exp_q.push_back(ts ? {t, pad} : p);
        i_req = 1;
        wait_busy(1);
        i_req = 0;
        wait_busy(0);
        cmp_cfg(cfg1, {rate, 2'b00, 1'b1, ts, 1'b0});
    endtask : run
    // Result side stalls at random to exercise the buffer.
    always @(posedge i_clk_sys)
        #2 rdy = 1'($random(seed));
    always @(posedge i_clk_sys)
        if (vld === 1'b1 && rdy === 1'b1)
        begin
            if (exp_q.size() == 0)
                cmp_res(res, 24'hxxxxxx);
            else
                cmp_res(res, exp_q.pop_front());
        end
    initial
    begin
        repeat (6) @(posedge i_clk_sys);
        #2 i_sys_rst = 0;
        run(1, 24'h000000, 14'h0960);
        run(1, 24'h000000, 14'h3ce0);
        run(0, 24'h800000, 14'h0000);
        run(0, 24'h000001, 14'h0000);
        run(0, 24'h7fffff, 14'h0000);
        run(0, 24'h000000, 14'h0000);
        for (int i = 0; i < 8; i++)
            run(i[0], 24'($random(seed)), 14'($random(seed)));
        n = 0;
        while (exp_q.size() > 0 && n < 3000)
        begin
            @(posedge i_clk_sys);
            n++;
        end
        if (exp_q.size() > 0)
            cmp_res(24'h000000, 24'h000001);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
